// [core/smc_stop_control.sv]
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "smc_params.svh"
// Function
// (RULE1) Stop disabled: stop gives illegal-opcode reset
// (RULE2) Debug enabled: light stop, clocks kept running
// (RULE3) Both detect bits: light stop, regulator on
// (RULE4) Otherwise power-down bit picks deep or light
// (RULE5) Stop halts clocks; reference clocks optional
// (RULE6) Debug enable written only by debug commands
// (RULE7) Light stop retains registers, RAM, pin levels
// (RULE8) Reset pin or pin interrupts end light stop
// (RULE9) Detector reset, warning, ADC, RTC, SCI wake
// (RULE10) Reset pin exit gives full reset
// (RULE11) Interrupt exit resumes at that vector
// (RULE12) Detector trips interrupt or reset as set
// (RULE13) Software keeps detector on for ADC
module smc_stop_control
    import smc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU core
    input wire logic stopExec,
    output logic illegalOpReset,
    output logic resetRequest,
    output logic wakeInterrupt,
    output logic [3:0] wakeSource,
    // Debug controller command port
    input wire logic dbgCmdWrite,
    input wire logic dbgCmdData,
    output logic debugModeEnable,
    // Wake sources
    input wire logic resetPin,
    input wire logic irqPin,
    input wire logic [7:0] portAPinIrq,
    input wire logic [7:0] portBPinIrq,
    input wire logic [7:0] portDPinIrq,
    input wire logic lowVoltageWarnIrq,
    input wire logic adcDoneIrq,
    input wire logic rtcIrq,
    input wire logic sciRxIrq,
    input wire logic supplyBelowThreshold,
    // Power control
    output logic coreClockEnable,
    output logic refClockEnable,
    output logic regulatorActive,
    output logic retainHold,
    output logic deepStopEnter,
    output logic irq
);
    // ************************************************
    // Registers
    // ************************************************
    smc_state_t state_reg, state_next;
    logic [`SMC_CTRL_W-1:0] ctrl_reg;
    logic [`SMC_EV_W-1:0] irqStat_reg, irqStat_next, irqMask_reg;
    logic dbgEn_reg, keepDbg_reg, keepReg_reg, lowPrev_reg;
    logic ack_reg, illegal_reg, resetReq_reg, wakeIrq_reg;
    logic [3:0] wakeSrc_reg;
    logic [31:0] rdData_reg;

    // ************************************************
    // Bus decode
    // ************************************************
    wire busReq = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wrLane0 = busReq & wb_we_i & wb_sel_i[0];
    wire rdAcc = busReq & ~wb_we_i;
    wire hitCtrl = (wb_adr_i == `SMC_CTRL_OFS);
    wire hitIrq = (wb_adr_i == `SMC_IRQ_OFS);
    wire hitMask = (wb_adr_i == `SMC_MASK_OFS);
    wire irqRead = rdAcc & hitIrq;
    wire [31:0] rdMux =
        hitCtrl ? {26'h0, ctrl_reg} :
        (wb_adr_i == `SMC_STAT_OFS) ?
            {24'h0, dbgEn_reg, state_reg, wakeSrc_reg} :
        hitIrq ? {28'h0, irqStat_reg} :
        hitMask ? {28'h0, irqMask_reg} : 32'h0;

    // Control fields
    wire stopEn = ctrl_reg[`SMC_STOPEN_BIT];
    wire detEn = ctrl_reg[`SMC_DETEN_BIT];
    wire detStopEn = ctrl_reg[`SMC_DETSTOP_BIT];
    wire pwrDownSel = ctrl_reg[`SMC_PWRDN_BIT];
    wire detRstMode = ctrl_reg[`SMC_DETRST_BIT];
    wire refOn = ctrl_reg[`SMC_REFON_BIT];
    wire inRun = (state_reg == SMC_RUN);
    wire inLight = (state_reg == SMC_LIGHT);
    wire inDeep = (state_reg == SMC_DEEP);

    // ************************************************
    // Stop mode selection
    // ************************************************
    wire stopTaken = stopExec & inRun;
    // (RULE1) disabled stop traps
    wire selIllegal = stopTaken & ~stopEn;
    // (RULE2) debug forces light stop
    wire selDbg = stopTaken & stopEn & dbgEn_reg;
    // (RULE3) detector keeps regulator
    wire selReg = stopTaken & stopEn & ~dbgEn_reg & detEn & detStopEn;
    // (RULE4) power-down bit selects depth
    wire selDeep = stopTaken & stopEn & ~dbgEn_reg
        & ~(detEn & detStopEn) & pwrDownSel;
    wire selLight = stopTaken & stopEn & ~selDeep;

    // ************************************************
    // Low-voltage detection
    // ************************************************
    // (RULE12) trip on falling supply
    wire detArmed = detEn & (inRun | detStopEn);
    wire detTrip = detArmed & supplyBelowThreshold & ~lowPrev_reg;
    wire detReset = detTrip & detRstMode;
    wire detIrq = detTrip & ~detRstMode;

    // ************************************************
    // Wake source priority
    // ************************************************
    // (RULE8) reset pin and pin interrupts
    // (RULE9) detector and peripheral wakes
    wire [3:0] wakeCode =
        resetPin ? `SMC_WK_RSTPIN :
        detReset ? `SMC_WK_DETRST :
        irqPin ? `SMC_WK_IRQ :
        (|portAPinIrq) ? `SMC_WK_PORTA :
        (|portBPinIrq) ? `SMC_WK_PORTB :
        (|portDPinIrq) ? `SMC_WK_PORTD :
        lowVoltageWarnIrq ? `SMC_WK_WARN :
        adcDoneIrq ? `SMC_WK_ADC :
        rtcIrq ? `SMC_WK_RTC :
        sciRxIrq ? `SMC_WK_SCI : `SMC_WK_NONE;
    wire wakeAny = (wakeCode != `SMC_WK_NONE);
    wire wakeIsReset = resetPin | detReset;
    wire lightWake = inLight & wakeAny;
    wire deepWake = inDeep & resetPin;

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SMC_RUN: begin
                if (selDeep) begin
                    state_next = SMC_DEEP;
                end else if (selLight) begin
                    state_next = SMC_LIGHT;
                end
            end
            SMC_LIGHT: begin
                if (wakeAny) begin
                    state_next = SMC_RUN;
                end
            end
            SMC_DEEP: begin
                if (resetPin) begin
                    state_next = SMC_RUN;
                end
            end
            default: state_next = SMC_RUN;
        endcase
    end

    // Sticky events, set wins over read clear
    always_comb begin
        irqStat_next = irqRead ? '0 : irqStat_reg;
        irqStat_next[`SMC_EV_STOP] |= selLight | selDeep;
        irqStat_next[`SMC_EV_WAKE] |= lightWake & ~wakeIsReset;
        irqStat_next[`SMC_EV_ILL] |= selIllegal;
        irqStat_next[`SMC_EV_DET] |= detIrq;
    end

    // ************************************************
    // Sequential state
    // ************************************************
    // State and wake bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SMC_RUN;
            keepDbg_reg <= 1'b0;
            keepReg_reg <= 1'b0;
            lowPrev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lowPrev_reg <= supplyBelowThreshold;
            if (stopTaken) begin
                keepDbg_reg <= selDbg;
                keepReg_reg <= selReg;
            end
        end
    end

    // CPU side pulses and held wake source
    always_ff @(posedge clk) begin
        if (rst) begin
            illegal_reg <= 1'b0;
            resetReq_reg <= 1'b0;
            wakeIrq_reg <= 1'b0;
            wakeSrc_reg <= `SMC_WK_NONE;
        end else begin
            illegal_reg <= selIllegal;
            // (RULE10) reset pin fully resets
            resetReq_reg <= selIllegal | resetPin | detReset;
            // (RULE11) interrupt wake, no reset
            wakeIrq_reg <= lightWake & ~wakeIsReset;
            if (lightWake | deepWake) begin
                wakeSrc_reg <= wakeCode;
            end
        end
    end

    // (RULE6) debug enable via debug port only
    always_ff @(posedge clk) begin
        if (rst) begin
            dbgEn_reg <= 1'b0;
        end else if (dbgCmdWrite) begin
            dbgEn_reg <= dbgCmdData;
        end
    end

    // Software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `SMC_CTRL_RST;
            irqMask_reg <= `SMC_MASK_RST;
            irqStat_reg <= '0;
        end else begin
            irqStat_reg <= irqStat_next;
            if (wrLane0 & hitCtrl) begin
                ctrl_reg <= wb_dat_i[`SMC_CTRL_W-1:0];
            end
            if (wrLane0 & hitMask) begin
                irqMask_reg <= wb_dat_i[`SMC_EV_W-1:0];
            end
        end
    end

    // Bus answer, one cycle after request
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdData_reg <= 32'h0;
        end else begin
            ack_reg <= busReq;
            if (rdAcc) begin
                rdData_reg <= rdMux;
            end
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;
    assign illegalOpReset = illegal_reg;
    assign resetRequest = resetReq_reg;
    assign wakeInterrupt = wakeIrq_reg;
    assign wakeSource = wakeSrc_reg;
    assign debugModeEnable = dbgEn_reg;
    // (RULE5) clocks halt in stop except debug light stop; refOn keeps ref clock
    assign coreClockEnable = inRun | (inLight & keepDbg_reg);
    assign refClockEnable = inRun | refOn | (inLight & keepDbg_reg);
    // (RULE3) regulator held in light stop kept by detector or debug
    assign regulatorActive = inRun
        | (inLight & (keepReg_reg | keepDbg_reg));
    // (RULE7) hold state in light stop
    assign retainHold = inLight;
    assign deepStopEnter = inDeep;
    assign irq = |(irqStat_reg & irqMask_reg);

    // ************************************************
    // Assertions
    // ************************************************
    // (RULE1) trap check
    ill_trap_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        stopExec && inRun && !stopEn
        |=> illegalOpReset && resetRequest && inRun)
        else $error("disabled stop did not trap");
    // (RULE2) debug stop keeps clocks
    dbg_clock_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        stopExec && inRun && stopEn && dbgEn_reg
        |=> inLight && coreClockEnable)
        else $error("debug stop lost clocks");
    // (RULE3) regulator kept
    reg_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        stopExec && inRun && stopEn && !dbgEn_reg && detEn && detStopEn
        |=> inLight && regulatorActive && !coreClockEnable)
        else $error("regulator not kept in stop");
    // (RULE4) deep selection
    deep_sel_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        stopExec && inRun && stopEn && !dbgEn_reg && !(detEn && detStopEn)
        |=> (pwrDownSel ? deepStopEnter : retainHold))
        else $error("wrong stop depth");
    // (RULE5) clocks off in plain stop
    clk_halt_a: assert property (@(posedge clk) disable iff (rst) // RULE5
        !inRun && !keepDbg_reg |-> !coreClockEnable
        && (refClockEnable == refOn))
        else $error("clock running in stop");
    // (RULE6) bus cannot change debug enable
    dbg_guard_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        !dbgCmdWrite |=> $stable(debugModeEnable))
        else $error("debug enable changed without command");
    // (RULE8) pin wake leaves light stop
    pin_wake_a: assert property (@(posedge clk) disable iff (rst) // RULE8
        inLight && (irqPin || |portBPinIrq) && !resetPin && !detReset
        |=> inRun && wakeInterrupt ##1 !wakeInterrupt)
        else $error("pin wake missed");
    // (RULE10) reset pin exit
    rst_exit_a: assert property (@(posedge clk) disable iff (rst) // RULE10
        inLight && resetPin |=> resetRequest && !wakeInterrupt
        && wakeSource == `SMC_WK_RSTPIN)
        else $error("reset pin exit wrong");
    // (RULE11) vector of waking interrupt
    vec_src_a: assert property (@(posedge clk) disable iff (rst) // RULE11
        inLight && !resetPin && !detReset && !irqPin
        && !(|portAPinIrq) && !(|portBPinIrq) && !(|portDPinIrq)
        && !lowVoltageWarnIrq && adcDoneIrq
        |=> wakeSource == `SMC_WK_ADC && !resetRequest)
        else $error("wrong wake vector");
    // (RULE12) detector in interrupt mode
    det_irq_a: assert property (@(posedge clk) disable iff (rst) // RULE12
        detEn && inRun && !detRstMode && $rose(supplyBelowThreshold)
        |=> irqStat_reg[`SMC_EV_DET])
        else $error("detector event lost");
    cv_light_c: cover property (@(posedge clk) inLight ##1 wakeInterrupt);
    cv_deep_c: cover property (@(posedge clk) inDeep ##1 resetRequest);
    cv_ill_c: cover property (@(posedge clk) illegalOpReset);
    cv_irq_c: cover property (@(posedge clk) irq && irqRead);
endmodule : smc_stop_control

// [core/smc_params.svh]
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
// Register byte offsets
`define SMC_CTRL_OFS 4'h0
`define SMC_STAT_OFS 4'h4
`define SMC_IRQ_OFS 4'h8
`define SMC_MASK_OFS 4'hC
// Control field positions
`define SMC_STOPEN_BIT 0
`define SMC_DETEN_BIT 1
`define SMC_DETSTOP_BIT 2
`define SMC_PWRDN_BIT 3
`define SMC_DETRST_BIT 4
`define SMC_REFON_BIT 5
`define SMC_CTRL_W 6
`define SMC_CTRL_RST 6'h00
// Interrupt status field positions
`define SMC_EV_STOP 0
`define SMC_EV_WAKE 1
`define SMC_EV_ILL 2
`define SMC_EV_DET 3
`define SMC_EV_W 4
`define SMC_MASK_RST 4'h0
// Wake source codes, highest priority first
`define SMC_WK_NONE 4'h0
`define SMC_WK_RSTPIN 4'h1
`define SMC_WK_DETRST 4'h2
`define SMC_WK_IRQ 4'h3
`define SMC_WK_PORTA 4'h4
`define SMC_WK_PORTB 4'h5
`define SMC_WK_PORTD 4'h6
`define SMC_WK_WARN 4'h7
`define SMC_WK_ADC 4'h8
`define SMC_WK_RTC 4'h9
`define SMC_WK_SCI 4'hA
`endif

// [core/smc_pkg.sv]
package smc_pkg;
    // Power state, one-hot
    typedef enum logic [2:0] {
        SMC_RUN = 3'b001,
        SMC_LIGHT = 3'b010,
        SMC_DEEP = 3'b100
    } smc_state_t;
endpackage : smc_pkg

// [test/smc_wake_model.sv]
`timescale 1ns/1ps
`include "smc_params.svh"
// ********************
// Wake source model
// ********************
module smc_wake_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic raiseReq,
    input wire logic [3:0] wakeCode,
    // Core answers
    input wire logic wakeInterrupt,
    input wire logic resetRequest,
    // Wake lines
    output logic resetPin,
    output logic irqPin,
    output logic [7:0] portAPinIrq,
    output logic [7:0] portBPinIrq,
    output logic [7:0] portDPinIrq,
    output logic lowVoltageWarnIrq,
    output logic adcDoneIrq,
    output logic rtcIrq,
    output logic sciRxIrq,
    output logic supplyBelowThreshold
);
    logic active_reg;
    logic [3:0] code_reg;
    // One source held until the core answers it
    always_ff @(posedge clk) begin
        if (rst) begin
            active_reg <= 1'h0;
            code_reg <= 4'h0;
        end else if (raiseReq) begin
            active_reg <= 1'h1;
            code_reg <= wakeCode;
        end else if (wakeInterrupt || resetRequest) begin
            active_reg <= 1'h0;
        end
    end
    // Line decode from the held source
    assign resetPin = active_reg && code_reg == `SMC_WK_RSTPIN;
    assign supplyBelowThreshold = active_reg && code_reg == `SMC_WK_DETRST;
    assign irqPin = active_reg && code_reg == `SMC_WK_IRQ;
    assign portAPinIrq = {active_reg && code_reg == `SMC_WK_PORTA, 7'h00};
    assign portBPinIrq = {7'h00, active_reg && code_reg == `SMC_WK_PORTB};
    assign portDPinIrq = {4'h0, active_reg && code_reg == `SMC_WK_PORTD, 3'h0};
    assign lowVoltageWarnIrq = active_reg && code_reg == `SMC_WK_WARN;
    assign adcDoneIrq = active_reg && code_reg == `SMC_WK_ADC;
    assign rtcIrq = active_reg && code_reg == `SMC_WK_RTC;
    assign sciRxIrq = active_reg && code_reg == `SMC_WK_SCI;
endmodule : smc_wake_model

// [test/testbench.sv]
`timescale 1ns/1ps
`include "smc_params.svh"
// ********************
// Stop control bench
// ********************
module testbench;
    localparam logic [31:0] STP = 32'h1 << `SMC_STOPEN_BIT;
    localparam logic [31:0] LVE = 32'h1 << `SMC_DETEN_BIT;
    localparam logic [31:0] LVS = 32'h1 << `SMC_DETSTOP_BIT;
    localparam logic [31:0] PPD = 32'h1 << `SMC_PWRDN_BIT;
    localparam logic [31:0] LRS = 32'h1 << `SMC_DETRST_BIT;
    localparam logic [31:0] REF = 32'h1 << `SMC_REFON_BIT;
    logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [3:0] adr = 4'h0, sel = 4'h0, wakeCode = 4'h0, code;
    logic [31:0] wdat = 32'h0, cv, rdat;
    logic stopExec = 1'h0, dbgW = 1'h0, dbgD = 1'h0, raiseReq = 1'h0;
    logic [31:0] wbDo;
    logic ack, illegalOpReset, resetRequest, wakeInterrupt, debugModeEnable;
    logic [3:0] wakeSource;
    logic coreClockEnable, refClockEnable, regulatorActive, retainHold;
    logic deepStopEnter, irq, resetPin, irqPin, warn, adc, rtc, sci, sup;
    logic [7:0] pa, pb, pd;
    int errors = 0, checkCount = 0, n;
    // Design and far side
    smc_stop_control dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wbDo), .wb_ack_o(ack),
        .stopExec(stopExec), .illegalOpReset(illegalOpReset),
        .resetRequest(resetRequest), .wakeInterrupt(wakeInterrupt),
        .wakeSource(wakeSource), .dbgCmdWrite(dbgW), .dbgCmdData(dbgD),
        .debugModeEnable(debugModeEnable), .resetPin(resetPin),
        .irqPin(irqPin), .portAPinIrq(pa), .portBPinIrq(pb),
        .portDPinIrq(pd), .lowVoltageWarnIrq(warn), .adcDoneIrq(adc),
        .rtcIrq(rtc), .sciRxIrq(sci), .supplyBelowThreshold(sup),
        .coreClockEnable(coreClockEnable), .refClockEnable(refClockEnable),
        .regulatorActive(regulatorActive), .retainHold(retainHold),
        .deepStopEnter(deepStopEnter), .irq(irq));
    smc_wake_model model_u (.clk(clk), .rst(rst), .raiseReq(raiseReq),
        .wakeCode(wakeCode), .wakeInterrupt(wakeInterrupt),
        .resetRequest(resetRequest), .resetPin(resetPin), .irqPin(irqPin),
        .portAPinIrq(pa), .portBPinIrq(pb), .portDPinIrq(pd),
        .lowVoltageWarnIrq(warn), .adcDoneIrq(adc), .rtcIrq(rtc),
        .sciRxIrq(sci), .supplyBelowThreshold(sup));
    // Clock
    initial forever #2 clk = ~clk;
    // ********************
    // Tasks
    // ********************
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %0s: expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // Classic single cycle, held until ack
    task automatic xfer(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk); while (ack !== 1'h1);
        rdat = wbDo;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask : xfer
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
        input string what);
        xfer(1'h0, a, 32'h0);
        chk(what, e, rdat);
    endtask : rd
    task automatic stop_cpu;
        @(posedge clk) stopExec <= 1'h1;
        @(posedge clk) stopExec <= 1'h0;
        #1;
    endtask : stop_cpu
    task automatic dbg(input logic v);
        @(posedge clk) dbgW <= 1'h1;
        dbgD <= v;
        @(posedge clk) dbgW <= 1'h0;
        #1;
    endtask : dbg
    // Raise one source, wait for the core to answer
    task automatic wake(input logic [3:0] c, input logic waitIt);
        @(posedge clk) raiseReq <= 1'h1;
        wakeCode <= c;
        @(posedge clk) raiseReq <= 1'h0;
        #1;
        n = 0;
        while (waitIt && (wakeInterrupt | resetRequest) !== 1'h1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wake
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // Watchdog
    initial begin
        #40000;
        errors++;
        complete_run();
    end
    // ********************
    // Tests
    // ********************
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        rd(`SMC_CTRL_OFS, 32'h0, "ctrl");
        rd(`SMC_STAT_OFS, 32'h10, "status");
        rd(`SMC_MASK_OFS, 32'h0, "mask");
        rd(4'h2, 32'h0, "unmapped");
        chk("clocks", 3'h7, {coreClockEnable, refClockEnable, regulatorActive});
        $display("test reset done");
        wr(`SMC_CTRL_OFS, 32'h0);
        stop_cpu();
        chk("illegal", 3'h6, {illegalOpReset, resetRequest, retainHold});
        rd(`SMC_IRQ_OFS, 32'h4, "events");
        rd(`SMC_IRQ_OFS, 32'h0, "events cleared");
        wr(`SMC_STAT_OFS, 32'h80);
        rd(`SMC_STAT_OFS, 32'h10, "status ro");
        dbg(1'h1);
        rd(`SMC_STAT_OFS, 32'h90, "debug on");
        chk("debug pin", 1'h1, debugModeEnable);
        $display("test illegal and debug done");
        wr(`SMC_CTRL_OFS, STP | PPD);
        stop_cpu();
        chk("debug stop", 3'h5, {retainHold, deepStopEnter, coreClockEnable});
        wake(`SMC_WK_IRQ, 1'h1);
        chk("debug wake", 5'h13, {wakeInterrupt, wakeSource});
        dbg(1'h0);
        chk("debug off", 1'h0, debugModeEnable);
        chk("masked", 1'h0, irq);
        wr(`SMC_MASK_OFS, 32'h3);
        #1 chk("irq", 1'h1, irq);
        rd(`SMC_IRQ_OFS, 32'h3, "events");
        #1 chk("irq cleared", 1'h0, irq);
        $display("test debug stop done");
        for (int c = 1; c <= 10; c++) begin
            code = 4'(c);
            cv = c == 2 ? STP | LVE | LVS | LRS : code[0] ? STP | LVE
                : STP | LVE | LVS | REF;
            wr(`SMC_CTRL_OFS, cv);
            stop_cpu();
            chk("light", {3'h4, ~code[0], cv[`SMC_REFON_BIT]}, {retainHold,
                deepStopEnter, coreClockEnable, regulatorActive,
                refClockEnable});
            wake(code, 1'h1);
            chk("wake", {c < 3, c > 2, code}, {resetRequest, wakeInterrupt,
                wakeSource});
            if (c > 2) rd(`SMC_CTRL_OFS, cv, "retained");
        end
        $display("test light stop done");
        wr(`SMC_CTRL_OFS, STP | PPD);
        stop_cpu();
        chk("deep", 3'h4, {deepStopEnter, coreClockEnable, refClockEnable});
        rd(`SMC_STAT_OFS, 32'h4A, "deep status");
        wake(`SMC_WK_IRQ, 1'h0);
        repeat (4) @(posedge clk);
        #1 chk("deep hold", 2'h2, {deepStopEnter, wakeInterrupt});
        wake(`SMC_WK_RSTPIN, 1'h1);
        chk("deep exit", 6'h21, {resetRequest, deepStopEnter, wakeSource});
        $display("test deep stop done");
        wr(`SMC_MASK_OFS, 32'h8);
        rd(`SMC_IRQ_OFS, 32'h3, "events");
        wr(`SMC_CTRL_OFS, STP | LVE);
        wake(`SMC_WK_DETRST, 1'h0);
        n = 0;
        while (irq !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("detector irq", 2'h1, {resetRequest, irq});
        rd(`SMC_IRQ_OFS, 32'h8, "detector event");
        wake(`SMC_WK_NONE, 1'h0);
        $display("test detector done");
        complete_run();
    end
endmodule : testbench
